// ### bench/tpwb_partner.sv
// Pulse source on both timer inputs and buzzer load on line 0.
// Assumes pins are sampled on the rising edge of the same clock.
module tpwb_partner (
  // Clock
  input  wire logic clk_sys,
  // Timer inputs
  output logic      pin0,
  output logic      pin1,
  // Buzzer line heard by the load
  input  wire logic line0_out,
  input  wire logic line0_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  int   tog  = 0;
  logic last = 1'h0;
  initial begin
    pin0 = 1'h0;
    pin1 = 1'h1;
  end
  // Load hears the line only while it is driven
  always @(posedge clk_sys) begin
    if (line0_oe === 1'h1 && line0_out !== last) tog++;
    last = line0_out;
  end
  task automatic set(input int n, input logic v);
    @(posedge clk_sys);
    if (n == 0) pin0 <= v;
    else pin1 <= v;
  endtask
  // One transition out, one back, then time for the stop to land
  task automatic pls(input int n, input int w);
    logic v;
    v = (n == 0) ? pin0 : pin1;
    set(n, !v);
    repeat (w - 1) @(posedge clk_sys);
    set(n, v);
    repeat (6) @(posedge clk_sys);
  endtask
endmodule

// ### bench/tpwb_top_asserts.sv
// Port-level checks for the timer/buzzer block, bound into its top.
// Assumes one bus slave whose hready is fed back from hreadyout.
module tpwb_top_asserts (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Register bus
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  input  wire logic        hreadyout,
  input  wire logic        hresp,
  // Pins
  input  wire logic        timer0_pullup_en,
  input  wire logic        timer1_pullup_en,
  input  wire logic        port_b_line0_out,
  input  wire logic        port_b_line0_oe,
  input  wire logic        port_b_line1_out,
  input  wire logic        port_b_line1_oe,
  input  wire logic        wake_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic       taken;
  logic       port_wr;
  logic [2:0] port_wr_q;
  logic       recent;
  assign taken   = hsel && htrans[1] && hready;
  assign port_wr = taken && hwrite && haddr[7:0] == tpwb_pkg::OFS_PORT;
  assign recent  = |port_wr_q;
  // Pin flops may trail the port register by one more edge
  always_ff @(posedge clk_sys) begin
    if (rst) port_wr_q <= 3'h0;
    else port_wr_q <= {port_wr_q[1:0], port_wr};
  end
  property p_ready; !rst |=> hreadyout; endproperty
  a_ready: assert property (p_ready) else $error("bus stalled");
  property p_okay; !hresp; endproperty
  a_okay: assert property (p_okay) else $error("error response");
  property p_rdzero; !(taken && !hwrite) |=> hrdata == 32'h0; endproperty
  a_rdzero: assert property (p_rdzero) else $error("stray read data");
  property p_wake; wake_pulse |=> !wake_pulse; endproperty
  a_wake: assert property (p_wake) else $error("wake too long");
  property p_pull;
    $changed({timer0_pullup_en, timer1_pullup_en}) |-> recent;
  endproperty
  a_pull: assert property (p_pull) else $error("pull changed");
  property p_oe;
    $changed({port_b_line0_oe, port_b_line1_oe}) |-> recent;
  endproperty
  a_oe: assert property (p_oe) else $error("enable changed");
  property p_pair;
    $changed(port_b_line0_out) && !recent |-> $changed(port_b_line1_out);
  endproperty
  a_pair: assert property (p_pair) else $error("lines apart");
  property p_comp;
    $changed(port_b_line0_out) && !recent |->
      port_b_line0_out != port_b_line1_out;
  endproperty
  a_comp: assert property (p_comp) else $error("not inverse");
  c_wake: cover property (wake_pulse);
  c_buzz: cover property ($changed(port_b_line0_out) && !recent);
  c_read: cover property (taken && !hwrite);
endmodule

bind tpwb_top tpwb_top_asserts chk_u (
  .clk_sys, .rst, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata,
  .hreadyout, .hresp, .timer0_pullup_en, .timer1_pullup_en,
  .port_b_line0_out, .port_b_line0_oe, .port_b_line1_out,
  .port_b_line1_oe, .wake_pulse
);

// ### bench/tpwb_top_tb.sv
// Self-checking bench for the timer/buzzer block over its register bus.
// Assumes the pulse source model drives both timer inputs.
module tpwb_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'h0;
  logic        rst     = 1'h1;
  logic        hsel    = 1'h0;
  logic        hwrite  = 1'h0;
  logic [1:0]  htrans  = 2'h0;
  logic [31:0] haddr   = 32'h0;
  logic [31:0] hwdata  = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, pin0, pin1, pu0, pu1;
  logic        o0, e0, o1, e1, irq0, irq1, wake;
  int          fails   = 0;
  int          checked = 0;
  int          wakes   = 0;

  tpwb_top dut_u (
    .clk_sys, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .timer0_input_pin(pin0), .timer1_input_pin(pin1),
    .timer0_pullup_en(pu0), .timer1_pullup_en(pu1),
    .port_b_line0_out(o0), .port_b_line0_oe(e0),
    .port_b_line1_out(o1), .port_b_line1_oe(e1),
    .timer0_irq(irq0), .timer1_irq(irq1), .wake_pulse(wake)
  );
  tpwb_partner pb_u (.clk_sys, .pin0, .pin1, .line0_out(o0),
                     .line0_oe(e0));

  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (wake === 1'h1) wakes++;

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    hsel   <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    do @(posedge clk_sys); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'h1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'h1, a, d, q);
  endtask
  // Tolerance covers the unsynchronised start and stop edges
  task automatic chk(input logic [7:0] a, input logic [31:0] e, input int t);
    logic [31:0] q;
    bus(1'h0, a, 32'h0, q);
    checked++;
    if (^q === 1'hX || q > e + t || q + t < e) begin
      fails++;
      $display("ERROR %0t read %h got %h exp %h", $time, a, q, e);
    end
  endtask
  task automatic chp(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("ERROR %0t pin got %h exp %h", $time, g, e);
    end
  endtask
  task automatic end_sim;
    if (fails == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'h0;
    chk(8'h14, 32'h0C, 0);
    chk(8'h18, 32'h0, 0);
    wr(8'h0C, 32'h0);
    wr(8'h08, 32'hC0);
    wr(8'h08, 32'hD0);
    repeat (20) @(posedge clk_sys);
    chk(8'h0C, 32'h0, 0);
    pb_u.pls(1, 40);
    chk(8'h0C, 32'hA, 1);
    chk(8'h08, 32'hC0, 0);
    pb_u.pls(1, 40);
    chk(8'h0C, 32'hA, 1);
    for (int p = 0; p < 8; p++) begin
      wr(8'h04, 32'h0);
      wr(8'h00, 32'hC8 + p);
      wr(8'h00, 32'hD8 + p);
      pb_u.pls(0, 8 << p);
      chk(8'h04, 32'h8, 1);
    end
    wr(8'h10, 32'h1);
    wr(8'h14, 32'hD1);
    wr(8'h04, 32'hF0);
    pb_u.set(0, 1'h1);
    wr(8'h00, 32'hD8);
    repeat (20) @(posedge clk_sys);
    chk(8'h04, 32'hF0, 0);
    pb_u.set(0, 1'h0);
    repeat (4) @(posedge clk_sys);
    chk(8'h00, 32'hD8, 0);
    pb_u.pls(0, 20);
    chk(8'h04, 32'hF4, 1);
    chk(8'h10, 32'h5, 0);
    chp(irq0, 1);
    chp(wakes, 1);
    chp(pb_u.tog, 1);
    chp(pu0, 1);
    chp(pu1, 1);
    chp({e0, e1}, 3);
    wr(8'h04, 32'hF0);
    wr(8'h00, 32'hD8);
    pb_u.pls(0, 20);
    chp(wakes, 1);
    chp(pb_u.tog, 2);
    wr(8'h14, 32'h1);
    repeat (2) @(posedge clk_sys);
    chp({o0, o1}, 0);
    wr(8'h14, 32'hD);
    repeat (2) @(posedge clk_sys);
    chp({e0, e1}, 0);
    wr(8'h10, 32'h4);
    repeat (2) @(posedge clk_sys);
    chp(irq0, 0);
    wr(8'h0C, 32'h0);
    wr(8'h08, 32'h40);
    wr(8'h08, 32'h50);
    repeat (3) pb_u.pls(1, 6);
    chk(8'h0C, 32'h3, 0);
    chk(8'h08, 32'h50, 0);
    wr(8'h08, 32'h0);
    wr(8'h08, 32'h10);
    repeat (3) pb_u.pls(1, 6);
    chk(8'h0C, 32'h3, 0);
    wr(8'h08, 32'h80);
    wr(8'h0C, 32'h0);
    wr(8'h08, 32'h90);
    repeat (40) @(posedge clk_sys);
    chk(8'h0C, 32'hA, 2);
    wr(8'h0C, 32'h8000);
    chk(8'h0C, 32'hC, 3);
    wr(8'h08, 32'h80);
    wr(8'h0C, 32'hFFFE);
    wr(8'h10, 32'h2);
    wr(8'h08, 32'h90);
    repeat (16) @(posedge clk_sys);
    chk(8'h10, 32'hA, 0);
    chp(irq1, 1);
    chp(wakes, 2);
    end_sim;
  end
  initial begin
    repeat (10000) @(posedge clk_sys);
    fails++;
    $display("ERROR %0t timeout", $time);
    end_sim;
  end
endmodule

// ### hdl/tpwb_pkg.sv
// Constants, register map and field layouts for the timer/buzzer block.
// Assumes a single 50 MHz system clock and an AHB-Lite register bus.
package tpwb_pkg;

  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_CNT0  = 8'h04;
  localparam logic [7:0] OFS_CTRL1 = 8'h08;
  localparam logic [7:0] OFS_CNT1  = 8'h0C;
  localparam logic [7:0] OFS_IRQ   = 8'h10;
  localparam logic [7:0] OFS_PORT  = 8'h14;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int IRQ_EN0   = 0;
  localparam int IRQ_EN1   = 1;
  localparam int IRQ_FLG0  = 2;
  localparam int IRQ_FLG1  = 3;
  localparam int PRT_BZEN  = 0;
  localparam int PRT_BZSRC = 1;
  localparam int PRT_DIR0  = 2;
  localparam int PRT_DIR1  = 3;
  localparam int PRT_DAT0  = 4;
  localparam int PRT_DAT1  = 5;
  localparam int PRT_PULL0 = 6;
  localparam int PRT_PULL1 = 7;

  // ------------------------------------------------------------
  // Reset values and counts
  // ------------------------------------------------------------
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [7:0]  PORT_RST = 8'h0C;
  localparam logic [1:0]  DIV4_LAST = 2'h3;
  localparam logic [15:0] MAX0 = 16'h00FF;
  localparam logic [15:0] MAX1 = 16'hFFFF;

  // Timer control byte, one per timer
  typedef enum logic [1:0] {
    MODE_IDLE  = 2'h0,
    MODE_EVENT = 2'h1,
    MODE_TIMER = 2'h2,
    MODE_PULSE = 2'h3
  } tpwb_mode_t;

  typedef struct packed {
    tpwb_mode_t mode;
    logic       rsv;
    logic       run_enable;
    logic       edge_select;
    logic [2:0] prescale_rate;
  } tpwb_ctrl_t;

endpackage

// ### hdl/tpwb_top.sv
// Two timer/event counters with pulse width measurement and buzzer pair.
// Assumes one AHB-Lite master, synchronous pin inputs, single clock.
//
// How it works
// [R01] Timer0 counts prescaled clock, timer1 clock/4
// [R02] Run-enable arms; count waits for active edge
// [R03] Edge select low: start falling, stop rising
// [R04] Edge select high: start rising, stop falling
// [R05] Only pulse width mode auto-clears run-enable
// [R06] Residual count held; inputs ignored until rearmed
// [R07] Start and stop follow transitions, not levels
// [R08] Overflow interrupts, reloads preload, keeps counting
// [R09] Program selects mode and input direction
// [R10] Pull-high option stays while pin counts
// [R11] Buzzer drives complementary pair on two lines
// [R12] Chosen timer overflow toggles buzzer pair
// [R13] Buzzer only drives lines set as outputs
// [R14] Line0 data bit gates buzzer; low drives zero
// [R15] External edge acts on next timer tick
// [R16] Counter read or preload write inhibits count
// [R17] Program loads count before enabling timer
// [R18] Overflow sets flag and wakes device
// [R19] Preset flag suppresses overflow wake-up
// [R20] Mode from control bits 7 and 6
// [R21] Preload write when stopped loads counter too
// [R22] Mode 10 timer, 01 event, 11 pulse, 00 idle
module tpwb_top (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Timer input pins
  input  wire logic        timer0_input_pin,
  input  wire logic        timer1_input_pin,
  output logic             timer0_pullup_en,
  output logic             timer1_pullup_en,
  // Buzzer / port lines
  output logic             port_b_line0_out,
  output logic             port_b_line0_oe,
  output logic             port_b_line1_out,
  output logic             port_b_line1_oe,
  // Events toward interrupt controller and power control
  output logic             timer0_irq,
  output logic             timer1_irq,
  output logic             wake_pulse
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  tpwb_pkg::tpwb_ctrl_t ctrl_r [2];
  logic [15:0] cnt_r [2];
  logic [15:0] pre_r [2];
  logic [1:0]  started_r;
  logic [1:0]  pin_r;
  logic [1:0]  pin_q;
  logic [1:0]  pin_vld_r;
  logic [6:0]  psc_r;
  logic [1:0]  div4_r;
  logic [7:0]  port_r;
  logic [3:0]  irq_r;
  logic        sound_out_true_r;

  logic        wr_q;
  logic [7:0]  addr_q;

  logic [1:0]  tick;
  logic [1:0]  inc;
  logic [1:0]  ovf;
  logic [1:0]  start;
  logic [1:0]  stop;
  logic [1:0]  inhibit;
  logic        addr_ok;
  logic [7:0]  addr_a;
  logic [31:0] rd_nxt;

  function automatic logic [7:0] ctrl_ofs(input int i);
    ctrl_ofs = (i == 0) ? tpwb_pkg::OFS_CTRL0 : tpwb_pkg::OFS_CTRL1;
  endfunction

  function automatic logic [7:0] cnt_ofs(input int i);
    cnt_ofs = (i == 0) ? tpwb_pkg::OFS_CNT0 : tpwb_pkg::OFS_CNT1;
  endfunction

  function automatic logic [15:0] cnt_max(input int i);
    cnt_max = (i == 0) ? tpwb_pkg::MAX0 : tpwb_pkg::MAX1;
  endfunction

  // Data-phase write hit on one register offset
  function automatic logic wr_hit(input logic [7:0] ofs);
    wr_hit = wr_q & (addr_q == ofs);
  endfunction

  // ------------------------------------------------------------
  // Bus address phase
  // ------------------------------------------------------------
  // Only the low address byte decodes; hsize is ignored
  assign addr_ok = hsel & htrans[1] & hready;
  assign addr_a  = haddr[7:0];

  always_comb begin
    rd_nxt = 32'h0000_0000;
    unique case (addr_a)
      tpwb_pkg::OFS_CTRL0: rd_nxt = {24'h000000, ctrl_r[0]};
      tpwb_pkg::OFS_CNT0:  rd_nxt = {16'h0000, cnt_r[0]};
      tpwb_pkg::OFS_CTRL1: rd_nxt = {24'h000000, ctrl_r[1]};
      tpwb_pkg::OFS_CNT1:  rd_nxt = {16'h0000, cnt_r[1]};
      tpwb_pkg::OFS_IRQ:   rd_nxt = {28'h0000000, irq_r};
      tpwb_pkg::OFS_PORT:  rd_nxt = {24'h000000, port_r};
      // Unmapped offsets read zero
      default:             rd_nxt = 32'h0000_0000;
    endcase
  end

  // Read data captured at the address phase: zero wait states
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_q      <= 1'b0;
      addr_q    <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      wr_q      <= addr_ok & hwrite;
      addr_q    <= addr_a;
      hrdata    <= (addr_ok & ~hwrite) ? rd_nxt : 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Timer clocks
  // ------------------------------------------------------------
  // Free-running dividers: a new rate applies at once
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      psc_r  <= 7'h00;
      div4_r <= 2'h0;
    end else begin
      psc_r  <= psc_r + 7'h01;
      div4_r <= div4_r + 2'h1;
    end
  end

  // Timer0 ticks every 2^rate clocks, timer1 every fourth
  always_comb begin
    tick[0] = ((psc_r & ((7'h01 << ctrl_r[0].prescale_rate) - 7'h01))
               == 7'h00); // R01
    tick[1] = (div4_r == tpwb_pkg::DIV4_LAST); // R01
  end

  // ------------------------------------------------------------
  // Pin edges and count decisions
  // ------------------------------------------------------------
  // History must fill first: a high idle pin would fake a rise
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_r     <= 2'h0;
      pin_q     <= 2'h0;
      pin_vld_r <= 2'h0;
    end else begin
      pin_r     <= {timer1_input_pin, timer0_input_pin};
      pin_q     <= pin_r;
      pin_vld_r <= {pin_vld_r[0], 1'b1};
    end
  end

  always_comb begin
    logic rise;
    logic fall;
    logic act;
    logic ret;
    rise = 1'b0;
    fall = 1'b0;
    act  = 1'b0;
    ret  = 1'b0;
    for (int i = 0; i < 2; i++) begin
      rise = pin_vld_r[1] & pin_r[i] & ~pin_q[i]; // R07
      fall = pin_vld_r[1] & ~pin_r[i] & pin_q[i]; // R07
      act  = ctrl_r[i].edge_select ? rise : fall; // R03 R04
      ret  = ctrl_r[i].edge_select ? fall : rise; // R03 R04
      // Reads of the count and preload writes hold the count still
      inhibit[i] = (addr_ok & ~hwrite & addr_a == cnt_ofs(i))
                 | wr_hit(cnt_ofs(i)); // R16
      start[i] = ctrl_r[i].run_enable & ~started_r[i] & act
               & (ctrl_r[i].mode == tpwb_pkg::MODE_PULSE); // R02
      // Auto-stop only in pulse mode; others need software
      stop[i]  = ctrl_r[i].run_enable & started_r[i] & ret
               & (ctrl_r[i].mode == tpwb_pkg::MODE_PULSE); // R03 R04
      unique case (ctrl_r[i].mode) // R20 R22
        tpwb_pkg::MODE_TIMER:
          inc[i] = ctrl_r[i].run_enable & tick[i];
        // Event mode counts raw pin edges, no prescaler
        tpwb_pkg::MODE_EVENT:
          inc[i] = ctrl_r[i].run_enable
                 & (ctrl_r[i].edge_select ? fall : rise);
        tpwb_pkg::MODE_PULSE:
          inc[i] = ctrl_r[i].run_enable & started_r[i]
                 & tick[i]; // R15
        tpwb_pkg::MODE_IDLE:
          inc[i] = 1'b0;
      endcase
      inc[i] = inc[i] & ~inhibit[i]; // R16
      ovf[i] = inc[i] & (cnt_r[i] == cnt_max(i)); // R08
    end
  end

  // ------------------------------------------------------------
  // Control registers and measurement state
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < 2; i++) begin
        ctrl_r[i] <= tpwb_pkg::CTRL_RST;
      end
      started_r <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        // Software write beats a same-cycle auto-stop
        if (wr_hit(ctrl_ofs(i))) begin
          ctrl_r[i] <= hwdata[7:0];
        end else if (stop[i]) begin
          ctrl_r[i].run_enable <= 1'b0; // R05 R06
        end
        // A fresh arm always waits for a new active edge
        if (~ctrl_r[i].run_enable | stop[i]) begin
          started_r[i] <= 1'b0; // R06
        end else if (start[i]) begin
          started_r[i] <= 1'b1; // R02
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Counters and preload
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < 2; i++) begin
        cnt_r[i] <= 16'h0000;
        pre_r[i] <= 16'h0000;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (wr_hit(cnt_ofs(i))) begin
          // Timer0 keeps only its low byte
          pre_r[i] <= hwdata[15:0] & cnt_max(i);
          // A running timer picks the value up at its next wrap
          if (~ctrl_r[i].run_enable) begin
            cnt_r[i] <= hwdata[15:0] & cnt_max(i); // R21
          end
        end else if (ovf[i]) begin
          cnt_r[i] <= pre_r[i]; // R08
        end else if (inc[i]) begin
          cnt_r[i] <= cnt_r[i] + 16'h0001;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Request flags, enables and wake-up
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_r      <= 4'h0;
      timer0_irq <= 1'b0;
      timer1_irq <= 1'b0;
      wake_pulse <= 1'b0;
    end else begin
      // Overflow beats a same-cycle software clear
      if (wr_hit(tpwb_pkg::OFS_IRQ)) begin
        irq_r <= hwdata[3:0] | {ovf, 2'h0}; // R18
      end else begin
        irq_r <= irq_r | {ovf, 2'h0}; // R18
      end
      timer0_irq <= irq_r[tpwb_pkg::IRQ_FLG0]
                  & irq_r[tpwb_pkg::IRQ_EN0]; // R08
      timer1_irq <= irq_r[tpwb_pkg::IRQ_FLG1]
                  & irq_r[tpwb_pkg::IRQ_EN1]; // R08
      // An already-set flag blocks the wake-up, enable or not
      wake_pulse <= |(ovf & ~irq_r[3:2]); // R18 R19
    end
  end

  // ------------------------------------------------------------
  // Port lines and buzzer
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      port_r <= tpwb_pkg::PORT_RST;
    end else if (wr_hit(tpwb_pkg::OFS_PORT)) begin
      port_r <= hwdata[7:0];
    end
  end

  // Toggles even while the outputs are gated off
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sound_out_true_r <= 1'b0;
    end else if (ovf[port_r[tpwb_pkg::PRT_BZSRC]]) begin
      sound_out_true_r <= ~sound_out_true_r; // R12
    end
  end

  // Direction bit high means input; buzzer only reaches output lines
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      port_b_line0_out <= 1'b0;
      port_b_line1_out <= 1'b0;
      port_b_line0_oe  <= 1'b0;
      port_b_line1_oe  <= 1'b0;
      timer0_pullup_en <= 1'b0;
      timer1_pullup_en <= 1'b0;
    end else begin
      port_b_line0_oe <= ~port_r[tpwb_pkg::PRT_DIR0]; // R13
      port_b_line1_oe <= ~port_r[tpwb_pkg::PRT_DIR1]; // R13
      if (port_r[tpwb_pkg::PRT_BZEN]) begin
        port_b_line0_out <= port_r[tpwb_pkg::PRT_DAT0]
                          & sound_out_true_r; // R11 R14
        port_b_line1_out <= port_r[tpwb_pkg::PRT_DAT0]
                          & ~sound_out_true_r; // R11 R14
      end else begin
        port_b_line0_out <= port_r[tpwb_pkg::PRT_DAT0];
        port_b_line1_out <= port_r[tpwb_pkg::PRT_DAT1];
      end
      timer0_pullup_en <= port_r[tpwb_pkg::PRT_PULL0]; // R10
      timer1_pullup_en <= port_r[tpwb_pkg::PRT_PULL1]; // R10
    end
  end

endmodule
